// File: inc/bha_pkg.sv
// Purpose: Shared constants and types for the bus hold and status arbiter
// Assumes: Single 50 MHz clock domain
// Notes:   Bus state codes mirror the processor bus sequencer
package bha_pkg;
  localparam logic       RST_GRANT = 1'h0;
  localparam logic       RST_NEED  = 1'h0;
  localparam logic       RST_LOCK  = 1'h0;
  localparam logic       RST_FLOAT = 1'h0;
  localparam logic [1:0] RST_SYNC  = 2'h0;
  // Pin synchroniser starts at the idle (deasserted) pin level, so no false reset follows
  localparam logic [1:0] RST_PIN   = 2'h3;

  typedef enum logic [1:0] {
    BHA_OWN  = 2'h0,
    BHA_HOLD = 2'h1
  } bha_own_t;

  typedef enum logic [1:0] {
    BHA_LK_IDLE = 2'h0,
    BHA_LK_READ = 2'h1,
    BHA_LK_WRITE = 2'h2
  } bha_lock_t;
endpackage

// File: inc/bha_need_if.sv
// Purpose: Carries bus-need causes between the arbiter and its status unit
// Assumes: One clock domain
// Notes:   need is registered in the status unit
`timescale 1ns/100ps
interface bha_need_if;
  logic queue_full;   // Bus queue full
  logic fetch_busy;   // Fetch pending or on the bus
  logic load_issued;  // Load posted to bus control unit
  logic drain_op;     // Queue-draining special operation
  logic need;         // Registered bus-need status
  modport src (output queue_full, output fetch_busy, output load_issued,
               output drain_op, input need);
  modport stat (input queue_full, input fetch_busy, input load_issued,
                input drain_op, output need);
endinterface

// File: rtl/bha_need_stat.sv
// Purpose: Registers the bus-need status from its causes
// Assumes: Causes come from same-clock logic
// Notes:   Stores alone never appear as a cause unless they fill the queue
`timescale 1ns/100ps
module bha_need_stat (
  input  wire logic clock,  // System clock
  input  wire logic rst_n,  // Synchronised reset, active low
  bha_need_if.stat  nif     // Need causes and status
);
  typedef struct packed {
    logic need;
  } bha_ns_st_t;

  bha_ns_st_t st;
  bha_ns_st_t next_st;

  always_comb begin
    next_st = st;
    // Any edge may change it; the far side treats it only as a warning
    next_st.need = nif.queue_full
                 | nif.fetch_busy
                 | nif.load_issued
                 | nif.drain_op;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st.need <= bha_pkg::RST_NEED;
    end else begin
      st <= next_st;
    end
  end

  assign nif.need = st.need;
endmodule

// File: rtl/bha_arbiter.sv
// Purpose: Processor-side bus hold handshake, lock and bus-need status
// Assumes: Hold request meets setup and hold on clock; nrst is asynchronous
// Notes:   Grant is registered, so it rises at the edge that samples the request

`timescale 1ns/100ps

// Notes on behaviour
// - Grant hold requests while reset is active
// - Reset waits until granted hold fully ends
// - Full bus queue raises bus-need status
// - Pending or active fetch raises bus-need
// - Issued load, including atomic read, raises it
// - Queue-draining special operations raise bus-need
// - Status may change any edge; only a hint
// - Plain stores do not raise bus-need
// - Atomic read sets lock; hold then ignored
// - Grant and float on recognising edge when idle
// - Drop grant on edge request is withdrawn
// - Never drop grant just to regain bus
// - Lock drops with last write transfer flag
module bha_arbiter (
  input  wire logic clock,              // System clock, 50 MHz
  input  wire logic nrst,               // Reset, active low, asynchronous
  input  wire logic reset_pin_n,        // Processor reset pin, active low, async
  input  wire logic bus_req,            // Alternate master hold request, sync
  input  wire logic idle_bus_state,     // Bus sequencer in idle state
  input  wire logic recovery_bus_state, // Bus sequencer in last recovery state
  input  wire logic queue_full,         // Bus queue in control unit is full
  input  wire logic fetch_busy,         // Fetch pending or on the bus
  input  wire logic load_issued,        // Load or atomic read posted
  input  wire logic drain_op,           // Special op draining the queue
  input  wire logic atomic_read_start,  // First cycle of atomic read
  input  wire logic atomic_write_last,  // Final write transfer of atomic
  output logic      bus_grant_ack,      // Bus surrendered to alternate master
  output logic      bus_float,          // Float processor bus outputs
  output logic      lock_out,           // Locked atomic access in progress
  output logic      bus_need_status,    // Processor may soon stall
  output logic      last_transfer_flag, // Last transfer indication
  output logic      reset_active        // Core may run reset activity
);
  typedef struct packed {
    logic [1:0]          rst_sync;
    logic [1:0]          pin_sync;
    bha_pkg::bha_own_t   own;
    bha_pkg::bha_lock_t  lk;
    logic                grant;
    logic                float_q;
    logic                lock;
    logic                last_q;
    logic                rst_act;
    logic                need_q;
  } bha_arb_st_t;

  bha_arb_st_t st;
  bha_arb_st_t next_st;
  logic        rst_n;
  logic        pin_rst;
  bha_need_if  nif ();

  assign nif.queue_full  = queue_full;
  assign nif.fetch_busy  = fetch_busy;
  assign nif.load_issued = load_issued;
  assign nif.drain_op    = drain_op;

  bha_need_stat u_need (
    .clock (clock),
    .rst_n (rst_n),
    .nif   (nif)
  );

  // Reset release synchroniser kept outside the struct so it can clear it
  logic [1:0] rsync;
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      rsync <= bha_pkg::RST_SYNC;
    end else begin
      rsync <= {rsync[0], 1'h1};
    end
  end
  assign rst_n   = rsync[1];
  assign pin_rst = ~st.pin_sync[1];

  always_comb begin
    next_st          = st;
    next_st.rst_sync = rsync;
    next_st.pin_sync = {st.pin_sync[0], reset_pin_n};
    next_st.last_q   = atomic_write_last;
    next_st.need_q   = nif.need;
    unique case (st.own)
      bha_pkg::BHA_OWN: begin
        // Bus idle during reset, so requests are served then too
        if (bus_req && !st.lock && (idle_bus_state || recovery_bus_state || pin_rst)) begin
          next_st.own     = bha_pkg::BHA_HOLD;
          next_st.grant   = 1'h1;
          next_st.float_q = 1'h1;
        end
      end
      bha_pkg::BHA_HOLD: begin
        // Own need is shown only on the status line, never by releasing
        if (!bus_req) begin
          next_st.own     = bha_pkg::BHA_OWN;
          next_st.grant   = 1'h0;
          next_st.float_q = 1'h0;
        end
      end
      default: begin
        next_st.own = bha_pkg::BHA_OWN;
      end
    endcase
    // Reset work stalls until the hold handshake has fully unwound
    // Resumes only the edge after the grant has actually been dropped
    next_st.rst_act = pin_rst && (st.own == bha_pkg::BHA_OWN)
                      && (next_st.own == bha_pkg::BHA_OWN);
    unique case (st.lk)
      bha_pkg::BHA_LK_IDLE: begin
        if (atomic_read_start) begin
          next_st.lk   = bha_pkg::BHA_LK_READ;
          next_st.lock = 1'h1;
        end
      end
      bha_pkg::BHA_LK_READ, bha_pkg::BHA_LK_WRITE: begin
        next_st.lk = bha_pkg::BHA_LK_WRITE;
        if (atomic_write_last) begin
          next_st.lk   = bha_pkg::BHA_LK_IDLE;
          next_st.lock = 1'h0;
        end
      end
      default: begin
        next_st.lk   = bha_pkg::BHA_LK_IDLE;
        next_st.lock = 1'h0;
      end
    endcase
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st.rst_sync <= bha_pkg::RST_SYNC;
      st.pin_sync <= bha_pkg::RST_PIN;
      st.own      <= bha_pkg::BHA_OWN;
      st.lk       <= bha_pkg::BHA_LK_IDLE;
      st.grant    <= bha_pkg::RST_GRANT;
      st.float_q  <= bha_pkg::RST_FLOAT;
      st.lock     <= bha_pkg::RST_LOCK;
      st.last_q   <= 1'h0;
      st.rst_act  <= 1'h0;
      st.need_q   <= bha_pkg::RST_NEED;
    end else begin
      st <= next_st;
    end
  end

  assign bus_grant_ack      = st.grant;
  assign bus_float          = st.float_q;
  assign lock_out           = st.lock;
  assign bus_need_status    = st.need_q;
  assign last_transfer_flag = st.last_q;
  assign reset_active       = st.rst_act;
endmodule

// File: tb/bha_arbiter_props.sv
// Purpose: Checker for the bus hold handshake, lock and bus-need status
// Assumes: Bound to bha_arbiter; one clock domain
// Notes:   Need status lags its causes by two edges
`timescale 1ns/100ps
module bha_arbiter_props (
  input wire logic clock, nrst, bus_req, idle_bus_state, recovery_bus_state,
  input wire logic queue_full, fetch_busy, load_issued, drain_op, reset_active,
  input wire logic atomic_read_start, atomic_write_last, lock_out, last_transfer_flag,
  input wire logic bus_grant_ack, bus_float, bus_need_status
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire cause = queue_full | fetch_busy | load_issued | drain_op;
  sequence s_free;
    bus_req && !lock_out && !bus_grant_ack && (idle_bus_state || recovery_bus_state);
  endsequence
  sequence s_quiet;
    !cause ##1 !cause;
  endsequence
  property p_grant; s_free |=> bus_grant_ack && bus_float; endproperty
  property p_drop; bus_grant_ack && !bus_req |=> !bus_grant_ack; endproperty
  property p_keep; bus_grant_ack && bus_req |=> bus_grant_ack; endproperty
  property p_block; lock_out && !bus_grant_ack |=> !bus_grant_ack; endproperty
  property p_lock; atomic_read_start |=> lock_out; endproperty
  property p_unlock; lock_out && atomic_write_last |=> !lock_out && last_transfer_flag; endproperty
  property p_need; cause |-> ##2 bus_need_status; endproperty
  property p_clear; s_quiet |=> !bus_need_status; endproperty
  property p_hold; bus_grant_ack && !reset_active |=> !reset_active; endproperty
  a_grant: assert property (p_grant) else $error("grant not given");
  a_drop: assert property (p_drop) else $error("grant not dropped");
  a_keep: assert property (p_keep) else $error("grant dropped early");
  a_block: assert property (p_block) else $error("grant while locked");
  a_lock: assert property (p_lock) else $error("lock not raised");
  a_unlock: assert property (p_unlock) else $error("lock not released");
  a_need: assert property (p_need) else $error("need missing");
  a_clear: assert property (p_clear) else $error("need stuck");
  a_hold: assert property (p_hold) else $error("reset ran in hold");
endmodule
bind bha_arbiter bha_arbiter_props i_props (.*);

// File: tb/bha_alt_master.sv
// Purpose: Alternate bus master asking for the shared bus
// Assumes: Same clock as the arbiter
// Notes:   Request follows want one edge late, like a registered master
`timescale 1ns/100ps
module bha_alt_master (
  input  wire logic clock,           // System clock
  input  wire logic want,            // Bench wants the bus
  input  wire logic bus_need_status, // Hint only
  output logic      bus_req          // Hold request
);
  initial bus_req = 1'h0;
  // Status is only a hint, so the request is never withdrawn because of it
  always @(posedge clock) bus_req <= #1 want;
  // Memory on this side is taken as burst capable; no non-burst path exists
endmodule

// File: tb/bus_hold_and_status_arbitration_tb_top.sv
// Purpose: Self-checking bench for the bus hold and status arbiter
// Assumes: Inputs change 1 ns after the rising edge
// Notes:   Plain stores have no port of their own
`timescale 1ns/100ps
module bus_hold_and_status_arbitration_tb_top;
  logic clock = 1'h0, nrst = 1'h0, pin_n = 1'h1, want = 1'h0, bus_req;
  logic idle = 1'h0, recov = 1'h0, qf = 1'h0, fb = 1'h0, li = 1'h0, dr = 1'h0;
  logic ars = 1'h0, awl = 1'h0, grant, flt, lock, need, last, ract;
  int   error_cnt = 0, checks = 0;
  bha_alt_master i_alt (.clock(clock), .want(want), .bus_need_status(need), .bus_req(bus_req));
  bha_arbiter i_dut (.clock(clock), .nrst(nrst), .reset_pin_n(pin_n), .bus_req(bus_req),
    .idle_bus_state(idle), .recovery_bus_state(recov), .queue_full(qf), .fetch_busy(fb),
    .load_issued(li), .drain_op(dr), .atomic_read_start(ars), .atomic_write_last(awl),
    .bus_grant_ack(grant), .bus_float(flt), .lock_out(lock), .bus_need_status(need),
    .last_transfer_flag(last), .reset_active(ract));
  initial forever #10 clock = ~clock;
  task automatic cyc(input int n); repeat (n) @(posedge clock); #1; endtask
  task automatic chk(input logic ok, input string m);
    checks++;
    if (ok !== 1'h1) begin
      error_cnt++;
      $display("wrong value at %0t: %s", $time, m);
    end
  endtask
  task automatic summarize;
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task automatic t_grant;
    idle = 1'h1;
    want = 1'h1;
    fb = 1'h1;
    cyc(2); chk(grant === 1'h1 && flt === 1'h1, "grant");
    cyc(3); chk(grant === 1'h1 && need === 1'h1, "keep");
    want = 1'h0;
    fb = 1'h0;
    cyc(2); chk(grant === 1'h0, "drop");
  endtask
  task automatic t_need;
    for (int i = 0; i < 4; i++) begin
      {qf, fb, li, dr} = 4'h8 >> i;
      cyc(2); chk(need === 1'h1, "need on");
      {qf, fb, li, dr} = 4'h0;
      cyc(2); chk(need === 1'h0, "need off");
    end
  endtask
  task automatic t_lock;
    idle = 1'h0;
    recov = 1'h1;
    ars = 1'h1;
    cyc(1); chk(lock === 1'h1, "lock");
    ars = 1'h0;
    want = 1'h1;
    cyc(4); chk(grant === 1'h0, "locked grant");
    awl = 1'h1;
    cyc(1); chk(lock === 1'h0 && last === 1'h1, "unlock");
    awl = 1'h0;
    cyc(1); chk(grant === 1'h1, "late grant");
    want = 1'h0;
    recov = 1'h0;
    cyc(2);
  endtask
  task automatic t_rst;
    idle = 1'h1;
    want = 1'h1;
    cyc(2);
    pin_n = 1'h0;
    idle = 1'h0;
    cyc(4); chk(grant === 1'h1 && ract === 1'h0, "reset in hold");
    want = 1'h0;
    cyc(2); chk(grant === 1'h0, "drop in reset");
    cyc(2); chk(ract === 1'h1, "reset resumes");
    want = 1'h1;
    cyc(2); chk(grant === 1'h1, "grant in reset");
    want = 1'h0;
    pin_n = 1'h1;
    cyc(4);
  endtask
  task automatic t_nrst;
    idle = 1'h1;
    want = 1'h1;
    cyc(3); chk(grant === 1'h1, "grant before reset");
    nrst = 1'h0;
    #1; chk(grant === 1'h0 && flt === 1'h0 && ract === 1'h0, "async reset");
    want = 1'h0;
    cyc(2);
    nrst = 1'h1;
    cyc(3); chk(grant === 1'h0 && ract === 1'h0, "after reset");
  endtask
  initial begin
    cyc(2);
    nrst = 1'h1;
    cyc(3);
    t_grant();
    t_need();
    t_lock();
    t_rst();
    t_nrst();
    summarize();
  end
  initial begin
    #5000;
    error_cnt++;
    summarize();
  end
endmodule
